// [ueis_top.sv]
// usb endpoint interrupt flags, vector and ahb-lite register slave
`timescale 1ns/1ps

module ueis_top
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        ep_done,
  input  wire logic        ep_dir_in,
  input  wire logic [2:0]  ep_num,
  input  wire logic        ep_iso,
  output logic             cpu_irq_line,
  output logic      [5:0]  vector_code,
  output logic             irq
);

  // byte address of a register index
  function automatic logic [31:0] byte_addr
  (
    input logic [15:0] idx
  );
    byte_addr = {14'h0000, idx, 2'b00};
  endfunction

  // address decode to a register id
  function automatic ueis_pkg::ueis_reg_t decode
  (
    input logic [31:0] a
  );
    // anything unmapped falls through to no register and reads zero
    if (a == byte_addr(ueis_pkg::VEC_IDX))
    begin
      decode = ueis_pkg::REG_VEC;
    end
    else if (a == byte_addr(ueis_pkg::IN_IDX))
    begin
      decode = ueis_pkg::REG_IN;
    end
    else if (a == byte_addr(ueis_pkg::OUT_IDX))
    begin
      decode = ueis_pkg::REG_OUT;
    end
    else if (a == byte_addr(ueis_pkg::STAT_IDX))
    begin
      decode = ueis_pkg::REG_STAT;
    end
    else if (a == byte_addr(ueis_pkg::MASK_IDX))
    begin
      decode = ueis_pkg::REG_MASK;
    end
    else
    begin
      decode = ueis_pkg::REG_NONE;
    end
  endfunction

  // fixed priority: highest bit index, i.e. highest code, wins
  function automatic logic [5:0] prio
  (
    input logic [15:0] f
  );
    logic [5:0] code;
    code = ueis_pkg::VEC_NONE;
    // scan upward so the highest set bit is the last one to land
    for (int i = 0; i < 16; i++)
    begin
      if (f[i])
      begin
        code = 6'(i);
      end
    end
    prio = code;
  endfunction

  // pending flags: out in bits 7:0, in in bits 15:8, bit = code
  logic [15:0]         flags_reg;
  logic [15:0]         flags_next;
  logic [15:0]         stat_reg;
  logic [15:0]         stat_next;
  logic [15:0]         mask_reg;
  logic [15:0]         mask_next;
  logic [5:0]          vec_reg;
  logic [5:0]          vec_next;
  logic                cpu_irq_reg;
  logic                cpu_irq_next;
  logic                irq_reg;
  logic                irq_next;

  // bus response state, kept in flops so the outputs leave registers
  logic                hready_reg;
  logic                hready_next;
  logic                hresp_reg;
  logic                hresp_next;

  // bus pipeline state
  ueis_pkg::ueis_reg_t dph_sel_reg;
  ueis_pkg::ueis_reg_t dph_sel_next;
  logic                dph_wr_reg;
  logic                dph_wr_next;
  logic [31:0]         rdata_reg;
  logic [31:0]         rdata_next;

  logic [15:0]         set_vec;
  logic [15:0]         clr_vec;
  logic [15:0]         w1c_vec;
  logic                aph_valid;
  logic                wr_vec;

  // address phase accepted; slave never stalls so hready is the bus's
  assign aph_valid = hsel && htrans[ueis_pkg::HTRANS_ACT_BIT] && hready;

  // completion events from the buffer manager
  always_comb
  begin
    set_vec = 16'h0000;
    // one completion per cycle, so a single index is ever set
    if (ep_done && !ep_iso)
    begin
      if (ep_dir_in)
      begin
        set_vec[ueis_pkg::VEC_IN_BASE[3:0] + {1'b0, ep_num}] = 1'b1;
      end
      else
      begin
        set_vec[ueis_pkg::VEC_OUT_BASE[3:0] + {1'b0, ep_num}] = 1'b1;
      end
    end
  end

  // write-side decode of the data phase
  // writes land at the data-phase end edge, while hwdata stands
  always_comb
  begin
    wr_vec  = dph_wr_reg && (dph_sel_reg == ueis_pkg::REG_VEC);
    clr_vec = 16'h0000;
    // only the flag behind the reported code is serviced
    if (wr_vec && (vec_reg != ueis_pkg::VEC_NONE))
    begin
      clr_vec[vec_reg[3:0]] = 1'b1;
    end
    w1c_vec = 16'h0000;
    if (dph_wr_reg && (dph_sel_reg == ueis_pkg::REG_STAT))
    begin
      w1c_vec = hwdata[15:0];
    end
  end

  // next state of flags, status, mask, vector and interrupt lines
  always_comb
  begin
    // flag registers take no direct writes; only a vector write clears one flag
    flags_next = (flags_reg & ~clr_vec) | set_vec;
    // status is sticky until ones are written; a new set still wins
    stat_next  = (stat_reg & ~w1c_vec) | set_vec;
    // mask gates only irq; the cpu line sees every pending flag
    mask_next  = mask_reg;
    if (dph_wr_reg && (dph_sel_reg == ueis_pkg::REG_MASK))
    begin
      mask_next = hwdata[15:0];
    end
    // code tracks the flags at the same edge, so a write advances it
    vec_next     = prio(flags_next);
    cpu_irq_next = |flags_next;
    irq_next     = |(stat_next & mask_next);
  end

  // flag and interrupt state registers
  // reset clears every flag, so no stale code survives it
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      flags_reg   <= {ueis_pkg::FLAGS_RST, ueis_pkg::FLAGS_RST};
      stat_reg    <= ueis_pkg::STAT_RST;
      mask_reg    <= ueis_pkg::MASK_RST;
      vec_reg     <= ueis_pkg::VEC_NONE;
      cpu_irq_reg <= 1'b0;
      irq_reg     <= 1'b0;
    end
    else
    begin
      flags_reg   <= flags_next;
      stat_reg    <= stat_next;
      mask_reg    <= mask_next;
      vec_reg     <= vec_next;
      cpu_irq_reg <= cpu_irq_next;
      irq_reg     <= irq_next;
    end
  end

  // bus pipeline: read data is loaded at the address phase edge so
  // hrdata leaves a flop with zero wait; the cost is that a read right
  // behind a write sees the value from before that write
  always_comb
  begin
    dph_sel_next = ueis_pkg::REG_NONE;
    dph_wr_next  = 1'b0;
    rdata_next   = 32'h0000_0000;
    if (aph_valid)
    begin
      dph_sel_next = decode(haddr);
      dph_wr_next  = hwrite;
      if (!hwrite)
      begin
        case (decode(haddr))
          ueis_pkg::REG_VEC:
          begin
            rdata_next = {26'h0000000, vec_reg};
          end
          ueis_pkg::REG_IN:
          begin
            rdata_next = {24'h000000, flags_reg[15:8]};
          end
          ueis_pkg::REG_OUT:
          begin
            rdata_next = {24'h000000, flags_reg[7:0]};
          end
          ueis_pkg::REG_STAT:
          begin
            rdata_next = {16'h0000, stat_reg};
          end
          ueis_pkg::REG_MASK:
          begin
            rdata_next = {16'h0000, mask_reg};
          end
          default:
          begin
            rdata_next = 32'h0000_0000;
          end
        endcase
      end
    end
  end

  // bus pipeline registers
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      dph_sel_reg <= ueis_pkg::REG_NONE;
      dph_wr_reg  <= 1'b0;
      rdata_reg   <= 32'h0000_0000;
    end
    else
    begin
      dph_sel_reg <= dph_sel_next;
      dph_wr_reg  <= dph_wr_next;
      rdata_reg   <= rdata_next;
    end
  end

  // response values: this slave never stalls and never errors; they are
  // kept as next values so a wait state or error could be added later
  always_comb
  begin
    hready_next = 1'b1;
    hresp_next  = 1'b0;
  end

  // response registers; ready leaves reset high so the bus never hangs
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hready_reg <= 1'b1;
      hresp_reg  <= 1'b0;
    end
    else
    begin
      hready_reg <= hready_next;
      hresp_reg  <= hresp_next;
    end
  end

  // hsize is not checked: only whole-word transfers are supported
  assign hrdata       = rdata_reg;
  assign hreadyout    = hready_reg;
  assign hresp        = hresp_reg;
  assign cpu_irq_line = cpu_irq_reg;
  assign vector_code  = vec_reg;
  assign irq          = irq_reg;

endmodule

// [ueis_pkg.sv]
// constants and types for the usb endpoint interrupt status block
package ueis_pkg;

  // register indices; byte address is four times the index
  localparam logic [15:0] VEC_IDX  = 16'hffb2;
  localparam logic [15:0] IN_IDX   = 16'hffb3;
  localparam logic [15:0] OUT_IDX  = 16'hffb4;
  localparam logic [15:0] STAT_IDX = 16'hffb5;
  localparam logic [15:0] MASK_IDX = 16'hffb6;

  // vector codes
  localparam logic [5:0]  VEC_OUT_BASE = 6'h00;
  localparam logic [5:0]  VEC_IN_BASE  = 6'h08;
  localparam logic [5:0]  VEC_NONE     = 6'h24;

  // reset values
  localparam logic [7:0]  FLAGS_RST = 8'h00;
  localparam logic [15:0] STAT_RST  = 16'h0000;
  localparam logic [15:0] MASK_RST  = 16'h0000;

  // ahb transfer type bit that marks nonseq or seq
  localparam int          HTRANS_ACT_BIT = 1;

  typedef enum logic [2:0]
  {
    REG_NONE,
    REG_VEC,
    REG_IN,
    REG_OUT,
    REG_STAT,
    REG_MASK
  } ueis_reg_t;

endpackage

// [ueis_top_assertions.sv]
// port checker for the endpoint interrupt block
`timescale 1ns/1ps
module ueis_checker
(
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        ep_done,
  input wire logic        ep_dir_in,
  input wire logic [2:0]  ep_num,
  input wire logic        ep_iso,
  input wire logic        cpu_irq_line,
  input wire logic [5:0]  vector_code
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic wv_reg;
  logic wv_next;
  // marks the data phase of a vector write, when the clear lands
  always_comb wv_next = hsel && htrans[1] && hready && hwrite
    && haddr == 32'h0003fec8;
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n) wv_reg <= 1'b0;
    else wv_reg <= wv_next;
  sequence s_take;
    ep_done && !ep_iso;
  endsequence
  sequence s_clr;
    wv_reg && cpu_irq_line;
  endsequence
  a_ep_sets: assert property (s_take |=> cpu_irq_line &&
    vector_code >= {2'h0, $past(ep_dir_in), $past(ep_num)})
    else $error("completion left no pending code");
  a_iso_quiet: assert property (ep_done && ep_iso && !cpu_irq_line
    |=> !cpu_irq_line) else $error("isochronous completion raised irq");
  a_idle_code: assert property (cpu_irq_line
    == (vector_code != 6'h24)) else $error("idle code and irq disagree");
  a_code_range: assert property (cpu_irq_line
    |-> vector_code <= 6'h0f) else $error("pending code out of range");
  a_vec_clear: assert property (s_clr and !ep_done
    |=> vector_code < $past(vector_code) || vector_code == 6'h24)
    else $error("vector write did not advance the code");
  a_vec_cause: assert property (!$stable(vector_code)
    |-> $past(ep_done) || $past(wv_reg))
    else $error("vector code changed without cause");
  a_irq_rise: assert property ($rose(cpu_irq_line)
    |-> $past(ep_done && !ep_iso)) else $error("irq rose without completion");
  a_set_wins: assert property (s_clr and s_take and
    {ep_dir_in, ep_num} == vector_code[3:0] |=> $stable(vector_code))
    else $error("clear beat a set on the same edge");
endmodule
bind ueis_top ueis_checker chk_u (.clk(clk), .rst_n(rst_n), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .ep_done(ep_done), .ep_dir_in(ep_dir_in), .ep_num(ep_num),
  .ep_iso(ep_iso), .cpu_irq_line(cpu_irq_line), .vector_code(vector_code));

// [ueis_bm_model.sv]
// buffer manager model reporting transaction completions
`timescale 1ns/1ps
module ueis_bm_model
(
  input wire logic  clk,
  output logic       ep_done = 1'b0,
  output logic       ep_dir_in = 1'b0,
  output logic [2:0] ep_num = 3'h0,
  output logic       ep_iso = 1'b0
);
  // one-cycle report; qualifiers are scrambled after so stale ones show up
  task automatic complete(input logic d, input logic [2:0] n, input logic i);
    @(posedge clk);
    ep_done <= 1'b1;
    ep_dir_in <= d;
    ep_num <= n;
    ep_iso <= i;
    @(posedge clk);
    ep_done <= 1'b0;
    ep_dir_in <= ~d;
    ep_num <= ~n;
    ep_iso <= ~i;
  endtask
endmodule

// [usb_endpoint_irq_status_test.sv]
// self-checking bench for the endpoint interrupt block
`timescale 1ns/1ps
module usb_endpoint_irq_status_test;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        hsel = 1'b0;
  logic        hwrite = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic [5:0]  vc;
  logic        rdy, hresp, done, dir, iso, cirq, irq;
  logic [2:0]  num;
  int          bad_count = 0;
  int          comparisons = 0;
  always #5 clk = ~clk;
  ueis_top dut_u (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(rdy), .hrdata(hrdata), .hreadyout(rdy), .hresp(hresp),
    .ep_done(done), .ep_dir_in(dir), .ep_num(num), .ep_iso(iso),
    .cpu_irq_line(cirq), .vector_code(vc), .irq(irq));
  ueis_bm_model bm_u (.clk(clk), .ep_done(done), .ep_dir_in(dir),
    .ep_num(num), .ep_iso(iso));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e)
    begin
      bad_count++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // one word transfer; read data taken at the data phase's closing edge
  task automatic bus(input logic w, input logic [15:0] i,
                     input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {14'h0, i, 2'h0};
    do @(posedge clk); while (rdy !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (rdy !== 1'b1);
    rd = hrdata;
    chk({31'h0, hresp}, 32'h0);
  endtask
  task automatic t_reset();
    bus(1'b0, ueis_pkg::VEC_IDX, 32'h0);
    chk(rd, 32'h24);
    bus(1'b0, ueis_pkg::IN_IDX, 32'h0);
    chk(rd, 32'h0);
    bus(1'b0, 16'h0001, 32'h0); // unmapped place
    chk(rd, 32'h0);
  endtask
  // isochronous completions leave flags and the cpu line alone
  task automatic t_iso();
    bm_u.complete(1'b0, 3'h6, 1'b1);
    bm_u.complete(1'b1, 3'h6, 1'b1);
    @(negedge clk);
    chk({31'h0, cirq}, 32'h0);
    bus(1'b0, ueis_pkg::OUT_IDX, 32'h0);
    chk(rd, 32'h0);
    bus(1'b0, ueis_pkg::IN_IDX, 32'h0);
    chk(rd, 32'h0);
  endtask
  // all sixteen pending; drained highest code first, flags ignore writes
  task automatic t_prio();
    for (int k = 0; k < 16; k++)
      bm_u.complete(k[3], k[2:0], 1'b0);
    @(negedge clk);
    chk({31'h0, cirq}, 32'h1);
    bus(1'b1, ueis_pkg::IN_IDX, 32'h0);
    bus(1'b1, ueis_pkg::OUT_IDX, 32'h0);
    bus(1'b0, ueis_pkg::IN_IDX, 32'h0);
    chk(rd, 32'hff);
    bus(1'b0, ueis_pkg::OUT_IDX, 32'h0);
    chk(rd, 32'hff);
    for (int k = 15; k >= 0; k--)
    begin
      @(negedge clk);
      chk({26'h0, vc}, k);
      bus(1'b1, ueis_pkg::VEC_IDX, 32'h0);
    end
    @(negedge clk);
    chk({26'h0, vc}, 32'h24);
    chk({31'h0, cirq}, 32'h0);
  endtask
  // sticky status gated by mask drives the level interrupt
  task automatic t_irq();
    bus(1'b1, ueis_pkg::STAT_IDX, 32'hffff);
    bm_u.complete(1'b1, 3'h3, 1'b0);
    @(negedge clk);
    chk({31'h0, irq}, 32'h0);
    bus(1'b0, ueis_pkg::STAT_IDX, 32'h0);
    chk(rd, 32'h0800);
    bus(1'b1, ueis_pkg::MASK_IDX, 32'h0800);
    repeat (2) @(negedge clk);
    chk({31'h0, irq}, 32'h1);
    bus(1'b0, ueis_pkg::MASK_IDX, 32'h0);
    chk(rd, 32'h0800);
    bus(1'b1, ueis_pkg::STAT_IDX, 32'h0800);
    repeat (2) @(negedge clk);
    chk({31'h0, irq}, 32'h0);
    bus(1'b1, ueis_pkg::VEC_IDX, 32'h0);
    @(negedge clk);
    chk({26'h0, vc}, 32'h24);
  endtask
  // a reset in mid-run drops the flag left pending by the race test
  task automatic t_rerun();
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(negedge clk);
    chk({26'h0, vc}, 32'h24);
    chk({31'h0, cirq}, 32'h0);
    bus(1'b0, ueis_pkg::OUT_IDX, 32'h0);
    chk(rd, 32'h0);
  endtask
  // completion on the clearing edge keeps its flag
  task automatic t_race();
    bm_u.complete(1'b0, 3'h5, 1'b0);
    fork
      bus(1'b1, ueis_pkg::VEC_IDX, 32'h0);
      begin
        @(posedge clk);
        bm_u.complete(1'b0, 3'h5, 1'b0);
      end
    join
    @(negedge clk);
    chk({26'h0, vc}, 32'h5);
  endtask
  task automatic final_report();
    $display("bad_count %0d comparisons %0d", bad_count, comparisons);
    if (bad_count == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    #30000;
    bad_count++;
    final_report();
  end
  initial
  begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_iso();
    t_prio();
    t_irq();
    t_race();
    t_rerun();
    final_report();
  end
endmodule
